/* hw/mailbox_and_bus_matching.sv */
// Purpose: Mail registers and bus width matching for a three port FIFO
// Assumes: Port clocks are slow next to sys_clk and are sampled as levels
// Notes: Port strobes and data are taken on the sampled port clock rise
`timescale 1ns/1ps
module mailbox_and_bus_matching (
	// System
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Configuration and master reset pins
	input  wire logic        master_reset_one_n,
	input  wire logic        master_reset_two_n,
	input  wire logic        big_endian_select,
	input  wire logic        port_b_width_select,
	input  wire logic        port_c_width_select,
	// Port A, two way 36 bit
	input  wire logic        port_a_clock,
	input  wire logic        port_a_chip_select_n,
	input  wire logic        port_a_write_not_read,
	input  wire logic        port_a_enable,
	input  wire logic        port_a_mail_select,
	input  wire logic [35:0] port_a_data_in,
	output logic [35:0]      port_a_data_out,
	output logic             port_a_data_oe_n,
	// Port B, 18 bit transmit
	input  wire logic        port_b_clock,
	input  wire logic        port_b_chip_select_n,
	input  wire logic        port_b_read_enable,
	input  wire logic        port_b_mail_select,
	output logic [17:0]      port_b_data,
	// Port C, 18 bit receive
	input  wire logic        port_c_clock,
	input  wire logic        port_c_write_enable,
	input  wire logic        port_c_mail_select,
	input  wire logic [17:0] port_c_data,
	// Flags
	output logic             mail_one_full_n,
	output logic             mail_two_full_n,
	output logic             fifo1_full_input_ready,
	output logic             fifo2_full_input_ready
);
	import mailbox_pkg::*;

	// Block state carried as one bundle
	typedef struct packed {
		cfg_state_type cfg;
		logic          big;
		logic          b_byte;
		logic          c_byte;
		logic [17:0]   mail_one;
		logic [17:0]   mail_two;
		logic          one_full_n;
		logic          two_full_n;
		logic [35:0]   b_hold;
		logic [1:0]    b_idx;
		logic [35:0]   c_build;
		logic [1:0]    c_idx;
		logic [35:0]   a_out;
		logic [17:0]   b_out;
	} state_type;

	localparam state_type ST_RESET = '{
		cfg: CFG_RESET, big: 1'b0, b_byte: 1'b0, c_byte: 1'b0,
		mail_one: MAIL_RESET, mail_two: MAIL_RESET,
		one_full_n: 1'b1, two_full_n: 1'b1,
		b_hold: LONG_RESET, b_idx: IDX_RESET,
		c_build: LONG_RESET, c_idx: IDX_RESET,
		a_out: LONG_RESET, b_out: MAIL_RESET};

	pins_type  raw;            // Pins gathered
	pins_type  sync1_reg;      // First synchroniser stage only
	pins_type  s;              // Second stage, safe to use
	logic [2:0] clk_prev_reg;  // Port clock history for edges
	state_type st_reg, st_next;
	logic      a_edge, b_edge, c_edge;
	logic      mrs_low;
	// FIFO handshakes
	logic        f1_in_valid, f1_in_ready, f1_out_valid, f1_out_ready;
	logic        f2_in_valid, f2_in_ready, f2_out_valid, f2_out_ready;
	logic [35:0] f1_out_data, f2_in_data, f2_out_data;
	logic        fifo_flush;

	assign raw = '{
		a_clock: port_a_clock, a_cs_n: port_a_chip_select_n,
		a_wnr: port_a_write_not_read, a_enable: port_a_enable,
		a_mail: port_a_mail_select, a_data: port_a_data_in,
		b_clock: port_b_clock, b_cs_n: port_b_chip_select_n,
		b_read: port_b_read_enable, b_mail: port_b_mail_select,
		c_clock: port_c_clock, c_write: port_c_write_enable,
		c_mail: port_c_mail_select, c_data: port_c_data,
		b_byte: port_b_width_select, c_byte: port_c_width_select,
		big: big_endian_select, mrs_one_n: master_reset_one_n,
		mrs_two_n: master_reset_two_n};

	// Lane of a part within the long word; first part is high in big endian
	function automatic logic [1:0] lane_of(input logic [1:0] idx,
		input logic big, input logic is_byte);
		if (is_byte) begin
			lane_of = big ? LAST_BYTE - idx : idx;
		end else begin
			lane_of = big ? LAST_WORD - idx : idx;
		end
	endfunction

	// Pick one part of a long word, placed in the low lines
	function automatic logic [17:0] part_get(input logic [35:0] w,
		input logic [1:0] idx, input logic big, input logic is_byte);
		logic [1:0] ln;
		ln = lane_of(idx, big, is_byte);
		if (is_byte) begin
			part_get = {PAD_ZERO, w[ln*BYTE_W +: BYTE_W]};
		end else begin
			part_get = w[ln[0]*HALF_W +: HALF_W];
		end
	endfunction

	// Drop one part into its lane of a long word
	function automatic logic [35:0] part_put(input logic [35:0] w,
		input logic [1:0] idx, input logic big, input logic is_byte,
		input logic [17:0] d);
		logic [1:0]  ln;
		logic [35:0] r;
		ln = lane_of(idx, big, is_byte);
		r  = w;
		if (is_byte) begin
			r[ln*BYTE_W +: BYTE_W] = d[8:0];
		end else begin
			r[ln[0]*HALF_W +: HALF_W] = d;
		end
		part_put = r;
	endfunction

	// Next part position, wrapping after the last part
	function automatic logic [1:0] idx_step(input logic [1:0] idx,
		input logic is_byte);
		logic [1:0] last;
		last     = is_byte ? LAST_BYTE : LAST_WORD;
		idx_step = (idx == last) ? IDX_RESET : idx + 1'b1;
	endfunction

	assign a_edge  = s.a_clock & ~clk_prev_reg[0];
	assign b_edge  = s.b_clock & ~clk_prev_reg[1];
	assign c_edge  = s.c_clock & ~clk_prev_reg[2];
	assign mrs_low = ~(s.mrs_one_n & s.mrs_two_n);

	// Next state for configuration, mail and width matching
	always_comb begin
		st_next      = st_reg;
		f1_in_valid  = 1'b0;
		f1_out_ready = 1'b0;
		f2_in_valid  = 1'b0;
		f2_out_ready = 1'b0;
		fifo_flush   = 1'b0;
		f2_in_data   = part_put(st_reg.c_build, st_reg.c_idx, st_reg.big,
			st_reg.c_byte, s.c_data);
		case (st_reg.cfg)
			CFG_RESET: begin
				// Levels track until the release; last sample wins
				st_next.big    = s.big;
				st_next.b_byte = s.b_byte;
				st_next.c_byte = s.c_byte;
				if (!mrs_low) begin
					st_next.cfg = CFG_RUN;
				end
			end
			CFG_RUN: begin
				// Port B read: mail or next FIFO1 part
				if (b_edge && !s.b_cs_n && s.b_read) begin
					if (s.b_mail) begin
						st_next.one_full_n = 1'b1;
						st_next.b_out      = st_reg.mail_one;
					end else if (st_reg.b_idx != IDX_RESET) begin
						// Rest of the long word from the hold register
						st_next.b_out = part_get(st_reg.b_hold, st_reg.b_idx,
							st_reg.big, st_reg.b_byte);
						st_next.b_idx = idx_step(st_reg.b_idx, st_reg.b_byte);
					end else if (f1_out_valid) begin
						// Whole long word leaves FIFO1 at once
						f1_out_ready  = 1'b1;
						st_next.b_hold = f1_out_data;
						st_next.b_out = part_get(f1_out_data, IDX_RESET,
							st_reg.big, st_reg.b_byte);
						st_next.b_idx = idx_step(IDX_RESET, st_reg.b_byte);
					end
				end
				// Port A access; mail write wins over a same cycle B read
				if (a_edge && !s.a_cs_n && s.a_enable) begin
					if (s.a_wnr && s.a_mail) begin
						if (st_reg.one_full_n) begin
							st_next.mail_one = st_reg.b_byte ?
								{PAD_ZERO, s.a_data[8:0]} : s.a_data[17:0];
							st_next.one_full_n = 1'b0;
						end
					end else if (s.a_wnr) begin
						f1_in_valid = 1'b1; // Dropped by FIFO1 when full
					end else if (s.a_mail) begin
						st_next.two_full_n = 1'b1;
						st_next.a_out = {st_reg.mail_two, MAIL_RESET};
					end else if (f2_out_valid) begin
						f2_out_ready  = 1'b1;
						st_next.a_out = f2_out_data;
					end
				end
				// Port C write; mail write wins over a same cycle A read
				if (c_edge && s.c_write) begin
					if (s.c_mail) begin
						if (st_reg.two_full_n) begin
							st_next.mail_two = st_reg.c_byte ?
								{PAD_ZERO, s.c_data[8:0]} : s.c_data;
							st_next.two_full_n = 1'b0;
						end
					end else if (f2_in_ready) begin
						st_next.c_build = f2_in_data;
						st_next.c_idx = idx_step(st_reg.c_idx, st_reg.c_byte);
						if (st_next.c_idx == IDX_RESET) begin
							f2_in_valid = 1'b1;
						end
					end
				end
			end
			default: begin
				st_next.cfg = CFG_RESET;
			end
		endcase
		// Master reset empties mail and restarts every part sequence
		if (mrs_low) begin
			fifo_flush         = 1'b1;
			st_next.cfg        = CFG_RESET;
			st_next.one_full_n = 1'b1;
			st_next.two_full_n = 1'b1;
			st_next.b_idx      = IDX_RESET;
			st_next.c_idx      = IDX_RESET;
			st_next.b_hold     = LONG_RESET;
			st_next.c_build    = LONG_RESET;
		end
	end

	// Synchroniser, edge history and block state
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			sync1_reg    <= '0;
			s            <= '0;
			clk_prev_reg <= 3'h0;
			st_reg       <= ST_RESET;
		end else begin
			sync1_reg    <= raw;
			s            <= sync1_reg;
			clk_prev_reg <= {s.c_clock, s.b_clock, s.a_clock};
			st_reg       <= st_next;
		end
	end

	// FIFO1 carries port A to port B
	word_fifo #(.WIDTH(LONG_W), .DEPTH(FIFO_DEPTH)) fifo1_inst (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.flush     (fifo_flush),
		.in_valid  (f1_in_valid),
		.in_ready  (f1_in_ready),
		.in_data   (s.a_data),
		.out_valid (f1_out_valid),
		.out_ready (f1_out_ready),
		.out_data  (f1_out_data)
	);

	// FIFO2 carries port C to port A
	word_fifo #(.WIDTH(LONG_W), .DEPTH(FIFO_DEPTH)) fifo2_inst (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.flush     (fifo_flush),
		.in_valid  (f2_in_valid),
		.in_ready  (f2_in_ready),
		.in_data   (f2_in_data),
		.out_valid (f2_out_valid),
		.out_ready (f2_out_ready),
		.out_data  (f2_out_data)
	);

	// Outputs; port A drives during a selected read and while the synchroniser holds its rstn zeros
	assign port_a_data_out        = st_reg.a_out;
	assign port_a_data_oe_n       = ~(~s.a_cs_n & ~s.a_wnr);
	assign port_b_data            = st_reg.b_out;
	assign mail_one_full_n        = st_reg.one_full_n;
	assign mail_two_full_n        = st_reg.two_full_n;
	assign fifo1_full_input_ready = (st_reg.cfg == CFG_RUN) & f1_in_ready;
	assign fifo2_full_input_ready = (st_reg.cfg == CFG_RUN) & f2_in_ready;
endmodule // mailbox_and_bus_matching

/* hw/mailbox_pkg.sv */
// Purpose: Shared constants and carriers for the mailbox and bus matching block
// Assumes: Every port is sampled on sys_clk after a two-flop synchroniser
// Notes: A high width select picks byte size on ports B and C
package mailbox_pkg;
	localparam int            LONG_W      = 36;         // FIFO word
	localparam int            HALF_W      = 18;         // Word size part
	localparam int            BYTE_W      = 9;          // Byte size part
	localparam int            FIFO_DEPTH  = 8;          // Buffer words
	localparam logic [17:0]   MAIL_RESET  = 18'h00000;  // Mail content at reset
	localparam logic [35:0]   LONG_RESET  = 36'h000000000;
	localparam logic [1:0]    IDX_RESET   = 2'h0;       // First part position
	localparam logic [1:0]    LAST_WORD   = 2'h1;       // Two words per long word
	localparam logic [1:0]    LAST_BYTE   = 2'h3;       // Four bytes per long word
	localparam logic [8:0]    PAD_ZERO    = 9'h000;     // Fill for unused lanes

	// Configuration sequencing around master reset
	typedef enum logic [1:0] {
		CFG_RESET = 2'b00,
		CFG_RUN   = 2'b01
	} cfg_state_type;

	// All pin inputs, sampled together
	typedef struct packed {
		logic        a_clock;
		logic        a_cs_n;
		logic        a_wnr;
		logic        a_enable;
		logic        a_mail;
		logic [35:0] a_data;
		logic        b_clock;
		logic        b_cs_n;
		logic        b_read;
		logic        b_mail;
		logic        c_clock;
		logic        c_write;
		logic        c_mail;
		logic [17:0] c_data;
		logic        b_byte;
		logic        c_byte;
		logic        big;
		logic        mrs_one_n;
		logic        mrs_two_n;
	} pins_type;
endpackage

/* hw/word_fifo.sv */
// Purpose: Flip-flop FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes: Flush empties it in one cycle
`timescale 1ns/1ps
module word_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             flush,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage array
	logic [PW-1:0]    wr_reg, wr_next;   // Write index
	logic [PW-1:0]    rd_reg, rd_next;   // Read index
	logic [PW:0]      cnt_reg, cnt_next; // Words held
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != DEPTH[PW:0]);
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem_reg[rd_reg];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	// Pointer and count update
	always_comb begin
		wr_next  = push ? wr_reg + 1'b1 : wr_reg;
		rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg;
		if (push & ~pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop & ~push) begin
			cnt_next = cnt_reg - 1'b1;
		end
		if (flush) begin
			wr_next  = '0;
			rd_next  = '0;
			cnt_next = '0;
		end
	end

	// Control registers
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_reg  <= '0;
			rd_reg  <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg  <= wr_next;
			rd_reg  <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// Data storage needs no reset; empty words are never shown valid
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
endmodule // word_fifo

/* verification/mailbox_checker.sv */
// Purpose: Port level assertions for the mailbox and bus matching block
// Assumes: Port strobes are held steady across each port clock pulse
// Notes: Port clocks pass a two-flop synchroniser, so answers come a few edges late
`timescale 1ns/1ps
module mailbox_checker (
	// System
	input wire logic sys_clk,
	input wire logic rstn,
	// Master reset pins
	input wire logic master_reset_one_n,
	input wire logic master_reset_two_n,
	// Port A controls
	input wire logic port_a_clock,
	input wire logic port_a_chip_select_n,
	input wire logic port_a_write_not_read,
	input wire logic port_a_enable,
	input wire logic port_a_mail_select,
	input wire logic port_a_data_oe_n,
	// Port B and C controls
	input wire logic port_b_clock,
	input wire logic port_b_chip_select_n,
	input wire logic port_b_read_enable,
	input wire logic port_b_mail_select,
	input wire logic port_c_clock,
	input wire logic port_c_write_enable,
	input wire logic port_c_mail_select,
	// Flags
	input wire logic mail_one_full_n,
	input wire logic mail_two_full_n,
	input wire logic fifo1_full_input_ready,
	input wire logic fifo2_full_input_ready
);
	// Decoded mail accesses, timing left to the properties
	wire a_mail = !port_a_chip_select_n && port_a_enable && port_a_mail_select;
	wire b_mail = !port_b_chip_select_n && port_b_read_enable && port_b_mail_select;
	wire c_mail = port_c_write_enable && port_c_mail_select;
	wire run    = master_reset_one_n && master_reset_two_n;

	// Single domain, so one clock and one disable for all
	default clocking cb_sys @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	a_mail_one_load:
	assert property ($rose(port_a_clock) && a_mail && port_a_write_not_read && mail_one_full_n
		|-> ##[2:6] !mail_one_full_n) else $error("mail one write not flagged");
	a_mail_two_load:
	assert property ($rose(port_c_clock) && c_mail && mail_two_full_n
		|-> ##[2:6] !mail_two_full_n) else $error("mail two write not flagged");
	a_mail_one_read:
	assert property ($rose(port_b_clock) && b_mail |-> ##[2:6] mail_one_full_n)
		else $error("mail one read did not free flag");
	a_mail_two_read:
	assert property ($rose(port_a_clock) && a_mail && !port_a_write_not_read
		|-> ##[2:6] mail_two_full_n) else $error("mail two read did not free flag");
	// Five quiet cycles cover the synchroniser lag of a late read
	a_mail_one_held:
	assert property ((!port_b_clock)[*5] ##0 (run && !mail_one_full_n) |=> !mail_one_full_n)
		else $error("mail one flag freed without a read");
	a_reset_state:
	assert property ((!master_reset_one_n)[*5] |-> mail_one_full_n && mail_two_full_n
		&& !fifo1_full_input_ready && !fifo2_full_input_ready)
		else $error("master reset state wrong");
	a_ready_rise:
	assert property ($rose(master_reset_one_n) && master_reset_two_n
		|-> ##[2:8] fifo1_full_input_ready && fifo2_full_input_ready)
		else $error("input ready late after master reset");
	a_oe_read:
	assert property ((!port_a_chip_select_n && !port_a_write_not_read)[*4] |-> !port_a_data_oe_n)
		else $error("port A not driving on read");

	// Main scenarios reached
	c_b_mail: cover property ($rose(port_b_clock) && b_mail);
	c_fifo1_full: cover property ($fell(fifo1_full_input_ready) && run);
	c_fifo2_full: cover property ($fell(fifo2_full_input_ready) && run);
	c_mail_two_free: cover property ($rose(mail_two_full_n) && run);
endmodule // mailbox_checker

bind mailbox_and_bus_matching mailbox_checker i_mailbox_checker (.*);

/* verification/port_host.sv */
// Purpose: Model of the parties on ports A, B and C plus the reset pins
// Assumes: Each access is one port clock pulse, edges on falling sys_clk
// Notes: Port clocks stand still between accesses; released data lines invert
`timescale 1ns/1ps
module port_host (
	// Clock and flags
	input  wire logic   sys_clk,
	input  wire logic   fifo1_full_input_ready,
	input  wire logic   fifo2_full_input_ready,
	// Configuration pins
	output logic        master_reset_one_n,
	output logic        master_reset_two_n,
	output logic        big_endian_select,
	output logic        port_b_width_select,
	output logic        port_c_width_select,
	// Port A
	output logic        port_a_clock,
	output logic        port_a_chip_select_n,
	output logic        port_a_write_not_read,
	output logic        port_a_enable,
	output logic        port_a_mail_select,
	output logic [35:0] port_a_data_in,
	// Ports B and C
	output logic        port_b_clock,
	output logic        port_b_chip_select_n,
	output logic        port_b_read_enable,
	output logic        port_b_mail_select,
	output logic        port_c_clock,
	output logic        port_c_write_enable,
	output logic        port_c_mail_select,
	output logic [17:0] port_c_data
);
	// Idle pins, master reset held with port C mail select high
	initial begin
		{master_reset_one_n, master_reset_two_n, big_endian_select} = '0;
		{port_b_width_select, port_c_width_select, port_a_clock, port_b_clock} = '0;
		{port_c_clock, port_a_write_not_read, port_a_enable, port_a_mail_select} = '0;
		{port_b_read_enable, port_b_mail_select, port_c_write_enable} = '0;
		{port_a_chip_select_n, port_b_chip_select_n, port_c_mail_select} = '1;
		port_a_data_in = 36'h000000000;
		port_c_data = 18'h00000;
	end

	// One clock pulse, each level well past the synchroniser
	task automatic pulse(input int p);
		repeat (4) @(negedge sys_clk);
		case (p)
			0: port_a_clock = 1'b1;
			1: port_b_clock = 1'b1;
			default: port_c_clock = 1'b1;
		endcase
		repeat (4) @(negedge sys_clk);
		{port_a_clock, port_b_clock, port_c_clock} = 3'h0;
	endtask

	// Master reset with new configuration; mail select C high until ready
	task automatic mreset(input logic bb, input logic cb, input logic be);
		{master_reset_one_n, master_reset_two_n} = 2'h0;
		port_c_mail_select = 1'b1;
		{port_b_width_select, port_c_width_select} = {bb, cb};
		big_endian_select = be;
		repeat (6) @(negedge sys_clk);
		{master_reset_one_n, master_reset_two_n} = 2'h3;
		for (int i = 0; i < 20 && !(fifo1_full_input_ready && fifo2_full_input_ready); i++)
			@(negedge sys_clk);
		port_c_mail_select = 1'b0;
		repeat (4) @(negedge sys_clk);
	endtask

	// Port A access, write or read
	task automatic a_cyc(input logic wr, input logic mb, input logic [35:0] d);
		{port_a_chip_select_n, port_a_enable} = 2'h1;
		{port_a_write_not_read, port_a_mail_select} = {wr, mb};
		port_a_data_in = d;
		pulse(0);
		{port_a_chip_select_n, port_a_enable} = 2'h2;
		port_a_data_in = ~d;
		repeat (3) @(negedge sys_clk);
	endtask

	// Port B read
	task automatic b_cyc(input logic mb);
		{port_b_chip_select_n, port_b_read_enable, port_b_mail_select} = {2'h1, mb};
		pulse(1);
		{port_b_chip_select_n, port_b_read_enable} = 2'h2;
		repeat (3) @(negedge sys_clk);
	endtask

	// Port C write
	task automatic c_cyc(input logic mb, input logic [17:0] d);
		{port_c_write_enable, port_c_mail_select} = {1'b1, mb};
		port_c_data = d;
		pulse(2);
		port_c_write_enable = 1'b0;
		port_c_data = ~d;
		repeat (3) @(negedge sys_clk);
	endtask
endmodule // port_host

/* verification/testbench.sv */
// Purpose: Self-checking bench for mail registers and width matching
// Assumes: Every access runs through the port host tasks
// Notes: Four configurations cover both orders and mixed widths
`timescale 1ns/1ps
module testbench;
	import mailbox_pkg::*;
	// Pins, named as the design ports
	logic sys_clk, rstn, master_reset_one_n, master_reset_two_n, big_endian_select;
	logic port_b_width_select, port_c_width_select, port_a_clock, port_a_chip_select_n;
	logic port_a_write_not_read, port_a_enable, port_a_mail_select, port_a_data_oe_n;
	logic port_b_clock, port_b_chip_select_n, port_b_read_enable, port_b_mail_select;
	logic port_c_clock, port_c_write_enable, port_c_mail_select;
	logic mail_one_full_n, mail_two_full_n, fifo1_full_input_ready, fifo2_full_input_ready;
	logic [35:0] port_a_data_in, port_a_data_out, lw;
	logic [17:0] port_b_data, port_c_data, exp;
	logic        bb, cb, be;        // Byte on B, byte on C, big endian
	int          err_count = 0;
	int          n_compared = 0;
	int          cycles = 0;
	localparam logic [2:0]  CFG [4] = '{3'h1, 3'h6, 3'h2, 3'h5};
	localparam logic [35:0] MAIL_A  = 36'hA5C39B1E7;

	mailbox_and_bus_matching i_mailbox_and_bus_matching (.*);
	port_host i_port_host (.*);

	// Clock
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	// Hang guard, well above the expected run
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			err_count++;
			final_report();
		end
	end

	task automatic check(input string what, input logic [35:0] e, input logic [35:0] s);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask

	// Part k of a long word in port order, unused lanes zero
	function automatic logic [17:0] part(input logic [35:0] l, input int k, input logic by);
		int          n;
		int          j;
		logic [35:0] s;
		n = by ? 4 : 2;
		j = be ? n - 1 - k : k;
		s = l >> (j * (by ? BYTE_W : HALF_W));
		part = by ? {9'h000, s[8:0]} : s[17:0];
	endfunction

	task automatic final_report;
		if (err_count == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Main sequence
	initial begin
		rstn = 1'b0;
		repeat (12) @(negedge sys_clk);
		rstn = 1'b1;
		for (int c = 0; c < 4; c++) begin
			{bb, cb, be} = CFG[c];
			i_port_host.mreset(bb, cb, be);
			check("mail flags", 36'h3, 36'({mail_one_full_n, mail_two_full_n}));
			check("ready", 36'h3, 36'({fifo1_full_input_ready, fifo2_full_input_ready}));
			// Mail one: second write must bounce, reads keep content
			i_port_host.a_cyc(1'b1, 1'b1, MAIL_A);
			check("mail one flag", 36'h0, 36'(mail_one_full_n));
			i_port_host.a_cyc(1'b1, 1'b1, 36'h000000000);
			exp = bb ? {9'h000, MAIL_A[8:0]} : MAIL_A[17:0];
			repeat (2) begin
				i_port_host.b_cyc(1'b1);
				check("mail one data", 36'(exp), 36'(port_b_data));
			end
			check("mail one flag", 36'h1, 36'(mail_one_full_n));
			// Mail two, byte size leaves upper C lines out
			i_port_host.c_cyc(1'b1, 18'h2D3C5);
			check("mail two flag", 36'h0, 36'(mail_two_full_n));
			i_port_host.c_cyc(1'b1, 18'h12345);
			i_port_host.a_cyc(1'b0, 1'b1, 36'h000000000);
			exp = cb ? 18'h001C5 : 18'h2D3C5;
			check("mail two data", 36'(exp), 36'(port_a_data_out[35:18]));
			check("mail two flag", 36'h1, 36'(mail_two_full_n));
			// FIFO2: fill with assembled long words, junk on unused C lines
			lw = 36'h9A5C3E1B7 + 36'(c);
			for (int w = 0; w < 8; w++)
				for (int k = 0; k < (cb ? 4 : 2); k++) begin
					exp = part(lw ^ {4{w[8:0]}}, k, cb);
					i_port_host.c_cyc(1'b0, cb ? {9'h1AB, exp[8:0]} : exp);
				end
			check("fifo2 ready", 36'h0, 36'(fifo2_full_input_ready));
			for (int w = 0; w < 8; w++) begin
				i_port_host.a_cyc(1'b0, 1'b0, 36'h000000000);
				check("fifo2 long word", lw ^ {4{w[8:0]}}, port_a_data_out);
			end
			check("fifo2 ready", 36'h1, 36'(fifo2_full_input_ready));
			// Read of an empty FIFO2 leaves the last word standing
			i_port_host.a_cyc(1'b0, 1'b0, 36'h000000000);
			check("fifo2 empty read", lw ^ {4{9'h007}}, port_a_data_out);
			check("port A idle", 36'h1, 36'(port_a_data_oe_n));
			// FIFO1: fill to refusal, then drain part by part
			for (int w = 0; w < 8; w++)
				i_port_host.a_cyc(1'b1, 1'b0, lw ^ {4{w[8:0]}});
			check("fifo1 ready", 36'h0, 36'(fifo1_full_input_ready));
			i_port_host.a_cyc(1'b1, 1'b0, 36'hFFFFFFFFF);
			for (int w = 0; w < 8; w++)
				for (int k = 0; k < (bb ? 4 : 2); k++) begin
					exp = part(lw ^ {4{w[8:0]}}, k, bb);
					i_port_host.b_cyc(1'b0);
					check("fifo1 part", 36'(exp), 36'(port_b_data));
				end
			check("fifo1 ready", 36'h1, 36'(fifo1_full_input_ready));
			i_port_host.b_cyc(1'b0);
			check("empty read", 36'(exp), 36'(port_b_data));
		end
		final_report();
	end
endmodule // testbench
